// ==== sram_ctl_consts.svh ====
/*
 * Constants for the asynchronous x16 static memory controller.
 * Assumes a 50 MHz mclk; every timing count derives from nanoseconds.
 */
`ifndef SRAM_CTL_CONSTS_SVH
`define SRAM_CTL_CONSTS_SVH

`define CLK_PERIOD_NS 20
`define T_POWER_NS 1000
`define T_ACCESS_NS 12
`define T_STROBE_DV_NS 8
`define T_RELEASE_NS 6
`define T_WSETUP_NS 8
`define T_DSETUP_NS 6
`define T_STANDBY_NS 12
// least times round up
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWER_CYC `CEIL_CYC(`T_POWER_NS)
`define READ_CYC `CEIL_CYC(`T_ACCESS_NS + `T_STROBE_DV_NS)
`define WRITE_CYC `CEIL_CYC(`T_WSETUP_NS + `T_RELEASE_NS + `T_DSETUP_NS)
`define IDLE_CYC `CEIL_CYC(`T_STANDBY_NS)

`endif

// ==== sram_ctl_pkg.sv ====
/*
 * Types shared by the controller, its checker, the memory model and the bench.
 * Assumes the constants header is compiled alongside.
 */
package sram_ctl_pkg;
    typedef enum logic [2:0] {
        ST_POWER,
        ST_IDLE,
        ST_READ,
        ST_WRITE,
        ST_RECOVER
    } ctl_state_e;
    typedef logic [15:0] word_t;
endpackage : sram_ctl_pkg

// ==== wait_counter.sv ====
/*
 * Down counter giving a one-cycle done pulse after a loaded count.
 * Assumes load and count values synchronous to mclk.
 */
`timescale 1ns/100ps
module wait_counter #(
    parameter int WIDTH = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    output logic done
);
    logic [WIDTH-1:0] cnt_ff;
    logic busy_ff;
    wire logic lastTick = busy_ff && (cnt_ff == '0);

    ////////////////////////////////////////////////////////////////////
    // a load restarts the wait; done fires once when it runs out
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_ff <= '0;
            busy_ff <= 1'b0;
        end else if (load) begin
            cnt_ff <= count;
            busy_ff <= 1'b1;
        end else if (lastTick) begin
            busy_ff <= 1'b0;
        end else if (busy_ff) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end
    // done must not look at load: the loader decides on done, and a
    // mask here would close a combinational loop through the caller
    assign done = lastTick;
endmodule : wait_counter

// ==== sram_ctl.sv ====
/*
 * Host-side controller for an asynchronous 16-bit static memory with
 * two byte lanes. One request at a time: read or write a word or lane.
 * Assumes the memory pins are driven straight from flops at 50 MHz, and
 * that the board joins dataOut/dataOe_n/dataIn onto the shared bus.
 */
`timescale 1ns/100ps
`include "sram_ctl_consts.svh"
module sram_ctl #(
    parameter int ADDR_W = 17,
    parameter int POWER_CYCLES = `POWER_CYC,
    parameter int READ_CYCLES = `READ_CYC,
    parameter int WRITE_CYCLES = `WRITE_CYC,
    parameter int IDLE_CYCLES = `IDLE_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    // user side
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [ADDR_W-1:0] reqAddr,
    input wire sram_ctl_pkg::word_t reqData,
    input wire logic [1:0] reqLanes,
    output logic reqReady,
    output logic rspValid,
    output sram_ctl_pkg::word_t rspData,
    output logic powerUp,
    // memory side
    output logic [ADDR_W-1:0] memAddr,
    output logic chip_select_n,
    output logic output_enable_n,
    output logic write_enable_n,
    output logic low_lane_strobe_n,
    output logic upper_lane_strobe_n,
    output sram_ctl_pkg::word_t dataOut,
    output logic [1:0] dataOe_n,
    input wire sram_ctl_pkg::word_t dataIn
);
    import sram_ctl_pkg::*;

    localparam int CW = 16;

    ctl_state_e state_ff, nxt_state;
    logic [ADDR_W-1:0] addr_ff;
    word_t wdata_ff, rdata_ff;
    logic [1:0] lanes_ff;
    logic cs_n_ff, oe_n_ff, we_n_ff;
    logic [1:0] strobe_n_ff, dataOe_n_ff;
    logic rsp_ff, power_ff;
    logic ldWait;
    logic [CW-1:0] ldCount;
    logic waitDone;

    ////////////////////////////////////////////////////////////////////
    // one counter times power-up, access, write pulse and recovery
    wait_counter #(.WIDTH(CW)) u_wait (
        .mclk(mclk),
        .rst(rst),
        .load(ldWait),
        .count(ldCount),
        .done(waitDone)
    );

    // a request is taken only when idle and at least one lane is chosen
    wire logic take = (state_ff == ST_IDLE) && reqValid && (reqLanes != 2'h0);
    wire logic takeRd = take && !reqWrite;
    wire logic takeWr = take && reqWrite;
    // counts are held one short: the counter spends a cycle on zero
    wire logic [CW-1:0] rdCnt = CW'(READ_CYCLES - 1);
    wire logic [CW-1:0] wrCnt = CW'(WRITE_CYCLES - 1);
    wire logic [CW-1:0] idCnt = CW'(IDLE_CYCLES - 1);
    wire logic [CW-1:0] pwCnt = CW'(POWER_CYCLES - 1);

    // power-up wait is armed on the first cycle after reset
    logic armed_ff;
    wire logic armPower = (state_ff == ST_POWER) && !armed_ff;

    ////////////////////////////////////////////////////////////////////
    // next state and counter loads
    always_comb begin
        nxt_state = state_ff;
        ldWait = 1'b0;
        ldCount = '0;
        case (state_ff)
            ST_POWER: begin
                ldWait = armPower;
                ldCount = pwCnt;
                if (waitDone) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (takeRd) begin
                    nxt_state = ST_READ;
                    ldWait = 1'b1;
                    ldCount = rdCnt;
                end else if (takeWr) begin
                    nxt_state = ST_WRITE;
                    ldWait = 1'b1;
                    ldCount = wrCnt;
                end
            end
            ST_READ, ST_WRITE: begin
                if (waitDone) begin
                    nxt_state = ST_RECOVER;
                    ldWait = 1'b1;
                    ldCount = idCnt;
                end
            end
            ST_RECOVER: begin
                if (waitDone) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // state register; the power wait load shares the counter port
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= ST_POWER;
            armed_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            armed_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // strobe timing: address and data latched at take, in the same
    // edge as the controls fall, and held through the ending edge
    wire logic endAccess = waitDone && (state_ff == ST_READ || state_ff == ST_WRITE);

    always_ff @(posedge mclk) begin
        if (rst) begin
            addr_ff <= '0;
            wdata_ff <= '0;
            lanes_ff <= 2'h0;
        end else if (take) begin
            addr_ff <= reqAddr;
            wdata_ff <= reqData;
            lanes_ff <= reqLanes;
        end
    end

    // select, strobes and enables all fall in the same edge and rise in
    // the same edge, so both setups equal the whole pulse
    always_ff @(posedge mclk) begin
        if (rst) begin
            cs_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            strobe_n_ff <= 2'h3;
            dataOe_n_ff <= 2'h3;
        end else if (take) begin
            cs_n_ff <= 1'b0;
            oe_n_ff <= reqWrite;
            we_n_ff <= !reqWrite;
            strobe_n_ff <= ~reqLanes;
            dataOe_n_ff <= reqWrite ? ~reqLanes : 2'h3;
        end else if (endAccess) begin
            // all rise together; bus data held a cycle past the end
            cs_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            strobe_n_ff <= 2'h3;
        end else if (state_ff == ST_RECOVER) begin
            dataOe_n_ff <= 2'h3;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data sampled per lane on the last access cycle
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            always_ff @(posedge mclk) begin
                if (rst) begin
                    rdata_ff[8*g +: 8] <= 8'h00;
                end else if (endAccess && state_ff == ST_READ) begin
                    rdata_ff[8*g +: 8] <= lanes_ff[g] ? dataIn[8*g +: 8]
                                                       : 8'h00;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (rst) begin
            rsp_ff <= 1'b0;
            power_ff <= 1'b0;
        end else begin
            rsp_ff <= endAccess && state_ff == ST_READ;
            power_ff <= (nxt_state != ST_POWER);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign reqReady = (state_ff == ST_IDLE);
    assign rspValid = rsp_ff;
    assign rspData = rdata_ff;
    assign powerUp = power_ff;
    assign memAddr = addr_ff;
    assign chip_select_n = cs_n_ff;
    assign output_enable_n = oe_n_ff;
    assign write_enable_n = we_n_ff;
    assign low_lane_strobe_n = strobe_n_ff[0];
    assign upper_lane_strobe_n = strobe_n_ff[1];
    assign dataOut = wdata_ff;
    assign dataOe_n = dataOe_n_ff;
endmodule : sram_ctl

// ==== sram_ctl_chk.sv ====
/* bus timing checker for the static memory controller pins.
   assumes one mclk domain and sync active-high rst. */
`timescale 1ns/100ps
module sram_ctl_chk #(
    parameter int ADDR_W = 17,
    parameter int POWER_CYCLES = 50,
    parameter int WRITE_CYCLES = 1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic rspValid,
    input wire logic [ADDR_W-1:0] memAddr,
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic low_lane_strobe_n,
    input wire logic upper_lane_strobe_n,
    input wire sram_ctl_pkg::word_t dataOut,
    input wire logic [1:0] dataOe_n
);
    import sram_ctl_pkg::*;
    int pwrCnt;
    int weCnt;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////
    // power count saturates, write count clears while high, so neither wraps
    always_ff @(posedge mclk) begin
        pwrCnt <= rst ? 0 : (pwrCnt < 4096 ? pwrCnt + 1 : pwrCnt);
        weCnt <= (rst || write_enable_n) ? 0 : weCnt + 1;
    end
    sequence rdStart;
        $fell(output_enable_n);
    endsequence
    sequence wrEnd;
        $rose(write_enable_n);
    endsequence
    AST_READ_WE_HIGH: assert property (!output_enable_n |-> write_enable_n)
        else $error("write enable low in read");
    AST_WRITE_START: assert property ($fell(write_enable_n) |->
        !chip_select_n && !(low_lane_strobe_n && upper_lane_strobe_n))
        else $error("write started without select and strobe");
    AST_ADDR_HELD: assert property (!chip_select_n && $past(!chip_select_n)
        |-> $stable(memAddr)) else $error("address moved while selected");
    AST_DATA_HELD: assert property (!write_enable_n && $past(!write_enable_n)
        |-> $stable(dataOut)) else $error("write data moved");
    AST_WRITE_LEN: assert property (wrEnd |-> weCnt >= WRITE_CYCLES)
        else $error("write pulse too short");
    AST_END_TOGETHER: assert property (wrEnd |-> chip_select_n)
        else $error("select not raised with write enable");
    AST_POWER_WAIT: assert property (!chip_select_n |-> pwrCnt >= POWER_CYCLES)
        else $error("access before power wait");
    AST_NO_CONTEND: assert property (!output_enable_n |-> dataOe_n == 2'b11)
        else $error("controller drives bus in read");
    AST_READ_ANSWER: assert property (rdStart |-> ##[1:4] rspValid)
        else $error("no read answer");
    AST_DESELECT_GAP: assert property ($rose(chip_select_n) |=> chip_select_n)
        else $error("no standby gap");
endmodule : sram_ctl_chk
bind sram_ctl sram_ctl_chk #(.ADDR_W(ADDR_W), .POWER_CYCLES(POWER_CYCLES),
    .WRITE_CYCLES(WRITE_CYCLES)) u_sram_ctl_chk (.mclk(mclk), .rst(rst),
    .rspValid(rspValid), .memAddr(memAddr), .chip_select_n(chip_select_n),
    .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
    .low_lane_strobe_n(low_lane_strobe_n), .dataOe_n(dataOe_n),
    .upper_lane_strobe_n(upper_lane_strobe_n), .dataOut(dataOut));

// ==== sram_model.sv ====
/* behavioural x16 static memory, 256 words, answers with zero delay.
   assumes pins come from flops on mclk; no pull on the data lines. */
`timescale 1ns/100ps
module sram_model (
    input wire logic mclk,
    input wire logic [16:0] memAddr,
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic low_lane_strobe_n,
    input wire logic upper_lane_strobe_n,
    input wire sram_ctl_pkg::word_t dataOut,
    input wire logic [1:0] dataOe_n,
    output sram_ctl_pkg::word_t dataIn
);
    import sram_ctl_pkg::*;
    word_t mem [256];
    word_t pat = 16'h3C5A;
    word_t bus;
    wire [1:0] lane = {~upper_lane_strobe_n, ~low_lane_strobe_n};
    wire wr = !chip_select_n && !write_enable_n;
    wire rd = !chip_select_n && !output_enable_n && write_enable_n;
    ////////////////////////////////////////////////////////////////////
    // undriven lanes wander so a stale value never reads back
    assign bus[7:0] = dataOe_n[0] ? pat[7:0] : dataOut[7:0];
    assign bus[15:8] = dataOe_n[1] ? pat[15:8] : dataOut[15:8];
    assign dataIn[7:0] = (rd && lane[0]) ? mem[memAddr[7:0]][7:0] : bus[7:0];
    assign dataIn[15:8] = (rd && lane[1]) ? mem[memAddr[7:0]][15:8] : bus[15:8];
    // last value before the rising edge is the one kept
    always @(negedge mclk) begin
        pat <= pat + 16'h1357;
        if (wr && lane[0]) mem[memAddr[7:0]][7:0] <= bus[7:0];
        if (wr && lane[1]) mem[memAddr[7:0]][15:8] <= bus[15:8];
    end
endmodule : sram_model

// ==== tb_sram_ctl.sv ====
/* self-checking bench: controller joined to the memory model.
   assumes a short power wait parameter to keep the run brief. */
`timescale 1ns/100ps
module tb_sram_ctl;
    import sram_ctl_pkg::*;
    localparam int PWR = 4;
    logic mclk = 0, rst = 1, reqValid = 0, reqWrite = 0;
    logic [16:0] reqAddr = '0, memAddr;
    logic [1:0] reqLanes = '0, dataOe_n;
    word_t reqData = '0, rspData, dataOut, dataIn, got;
    logic reqReady, rspValid, powerUp, csN, oeN, weN, llN, ulN;
    int fail_count = 0, checked = 0;
    always #10 mclk = ~mclk;
    sram_ctl #(.POWER_CYCLES(PWR)) u_sram_ctl (.mclk(mclk), .rst(rst),
        .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
        .reqData(reqData), .reqLanes(reqLanes), .reqReady(reqReady),
        .rspValid(rspValid), .rspData(rspData), .powerUp(powerUp),
        .memAddr(memAddr), .chip_select_n(csN), .output_enable_n(oeN),
        .write_enable_n(weN), .low_lane_strobe_n(llN), .dataIn(dataIn),
        .upper_lane_strobe_n(ulN), .dataOut(dataOut), .dataOe_n(dataOe_n));
    sram_model u_sram_model (.mclk(mclk), .memAddr(memAddr),
        .chip_select_n(csN), .output_enable_n(oeN), .write_enable_n(weN),
        .low_lane_strobe_n(llN), .upper_lane_strobe_n(ulN),
        .dataOut(dataOut), .dataOe_n(dataOe_n), .dataIn(dataIn));
    ////////////////////////////////////////////////////////////////////
    task chk(string name, logic [31:0] s, logic [31:0] e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, e, s);
        end
    endtask : chk
    task complete_run;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task tmo(int n, int lim);
        if (n >= lim) begin
            fail_count++;
            complete_run;
        end
    endtask : tmo
    // request held until the edge that takes it; reads wait for answer
    task access(logic w, logic [16:0] a, word_t d, logic [1:0] l);
        int n;
        @(posedge mclk);
        {reqValid, reqWrite, reqAddr, reqData, reqLanes} <= {1'b1, w, a, d, l};
        n = 0;
        do begin @(posedge mclk); n++; end while (reqReady !== 1'b1 && n < 100);
        tmo(n, 100);
        reqValid <= 0;
        n = 0;
        while (!w && rspValid !== 1'b1 && n < 20) begin @(posedge mclk); n++; end
        tmo(n, 20);
        got = rspData;
    endtask : access
    task scen_power;
        int n;
        n = 0;
        while (powerUp !== 1'b1 && n < 50) begin
            @(posedge mclk);
            n++;
            chk("cs_n in wait", csN, 1'b1);
        end
        tmo(n, 50);
        chk("power wait long enough", n >= PWR, 1);
    endtask : scen_power
    task scen_word;
        access(1, 17'h00010, 16'hA5C3, 2'b11);
        access(1, 17'h1FFFF, 16'h5A3C, 2'b11);
        access(0, 17'h00010, 16'h0000, 2'b11);
        chk("word read", got, 16'hA5C3);
        access(0, 17'h1FFFF, 16'h0000, 2'b11);
        chk("top address read", got, 16'h5A3C);
    endtask : scen_word
    task scen_lanes;
        access(1, 17'h00010, 16'hFF12, 2'b01);
        access(1, 17'h00010, 16'h96FF, 2'b10);
        access(0, 17'h00010, 16'h0000, 2'b11);
        chk("merged lanes", got, 16'h9612);
        access(0, 17'h00010, 16'h0000, 2'b10);
        chk("upper lane only", got, 16'h9600);
        access(0, 17'h00010, 16'h0000, 2'b01);
        chk("low lane only", got, 16'h0012);
    endtask : scen_lanes
    task scen_refuse;
        @(posedge mclk);
        {reqValid, reqWrite, reqLanes} <= {1'b1, 1'b1, 2'b00};
        repeat (6) begin @(posedge mclk); chk("empty lanes", csN, 1'b1); end
        reqValid <= 0;
    endtask : scen_refuse
    // reset in the recovery cycle just after a write must leave every control high
    task scen_midreset;
        int n;
        @(posedge mclk);
        {reqValid, reqWrite, reqAddr, reqLanes} <= {1'b1, 1'b1, 17'h20, 2'b11};
        n = 0;
        do begin @(posedge mclk); n++; end while (csN !== 1'b0 && n < 20);
        tmo(n, 20);
        {rst, reqValid} <= 2'b10;
        repeat (2) @(posedge mclk);
        chk("controls after reset", {csN, weN, oeN, llN, ulN}, 5'h1F);
        chk("bus released", dataOe_n, 2'b11);
        rst <= 0;
        scen_power;
        access(0, 17'h00010, 16'h0000, 2'b11);
        chk("data kept", got, 16'h9612);
    endtask : scen_midreset
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 0;
        scen_power;
        scen_word;
        scen_lanes;
        scen_refuse;
        scen_midreset;
        complete_run;
    end
endmodule : tb_sram_ctl
